// file: tb/dsz_exec_bench.sv
// self-checking bench of the decrement-and-skip-on-zero executor
`default_nettype none
module dsz_exec_bench import dsz_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic                   i_sys_clk    = 1'b0;
    logic                   i_resetn     = 1'b0;
    logic                   i_start      = 1'b0;
    dsz_req_s               i_req        = '0;
    logic [DSZ_PC_W-1:0]    i_pc         = '0;
    logic [DSZ_BSR_W-1:0]   i_bsr        = '0;
    logic                   i_ext_en     = 1'b0;
    logic [DSZ_ADDR_W-1:0]  i_index_base = '0;
    logic [DSZ_DATA_W-1:0]  i_rd_data    = '0;
    logic                   o_rd_en;
    logic [DSZ_ADDR_W-1:0]  o_addr;
    logic                   o_wr_en;
    logic [DSZ_DATA_W-1:0]  o_wr_data;
    logic                   o_w_wr_en;
    logic [DSZ_DATA_W-1:0]  o_w_data;
    logic                   o_busy;
    logic [1:0]             o_phase;
    logic                   o_flush;
    logic                   o_done;
    logic [1:0]             o_cycles;
    logic [DSZ_PC_W-1:0]    o_pc;
    int                     failures     = 0;
    int                     checks_done  = 0;
    // expected phase of the nth clock after issue; the order repeats every four clocks
    function automatic logic [1:0] phase_of(input int n);
        case ((n - 1) % 4)
            0:       return DSZ_Q1;
            1:       return DSZ_Q2;
            2:       return DSZ_Q3;
            default: return DSZ_Q4;
        endcase
    endfunction : phase_of

    // each rising edge is one phase, so 10 ns per phase
    always #5 i_sys_clk = ~i_sys_clk;

    dsz_exec i_dsz_exec (
        .i_sys_clk    (i_sys_clk),
        .i_resetn     (i_resetn),
        .i_start      (i_start),
        .i_req        (i_req),
        .i_pc         (i_pc),
        .i_bsr        (i_bsr),
        .i_ext_en     (i_ext_en),
        .i_index_base (i_index_base),
        .i_rd_data    (i_rd_data),
        .o_rd_en      (o_rd_en),
        .o_addr       (o_addr),
        .o_wr_en      (o_wr_en),
        .o_wr_data    (o_wr_data),
        .o_w_wr_en    (o_w_wr_en),
        .o_w_data     (o_w_data),
        .o_busy       (o_busy),
        .o_phase      (o_phase),
        .o_flush      (o_flush),
        .o_done       (o_done),
        .o_cycles     (o_cycles),
        .o_pc         (o_pc)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // issues one instruction and follows it cycle by cycle until done;
    // read data is wrong outside the read cycle so a mistimed read shows up
    task automatic run_op(input string name, input logic [7:0] fa, input logic dest,
                          input logic bank, input logic two, input logic [3:0] bank_select_register,
                          input logic ext, input logic [11:0] base, input logic [7:0] rd,
                          input logic [11:0] exp_addr);
        logic [7:0]  res;
        logic        zero;
        logic [1:0]  cyc;
        logic [20:0] pc;
        int          done_n;
        res    = rd - 8'h01;
        zero   = (res === 8'h00);
        cyc    = zero ? (two ? 2'h3 : 2'h2) : 2'h1;
        done_n = zero ? (two ? 13 : 9) : 5;
        pc     = 21'h0abc40;
        @(posedge i_sys_clk);
        i_start      <= 1'b1;
        i_req        <= '{f: fa, dest: dest, bank: bank, two_word: two};
        i_pc         <= pc;
        i_bsr        <= bank_select_register;
        i_ext_en     <= ext;
        i_index_base <= base;
        i_rd_data    <= ~rd;
        @(posedge i_sys_clk);
        i_start <= 1'b0;
        for (int n = 1; n <= done_n; n++) begin
            if (n > 1) begin
                @(posedge i_sys_clk);
                i_rd_data <= (n == 3) ? rd : ~rd;
            end
            #1;
            chk("busy", n < done_n, o_busy);
            if (n < done_n) chk("phase", phase_of(n), o_phase);
            chk("rd_en", n == 3, o_rd_en);
            chk("wr_en", n == 5 && dest, o_wr_en);
            chk("w_wr_en", n == 5 && !dest, o_w_wr_en);
            chk("flush", n == 5 && zero, o_flush);
            chk("done", n == done_n, o_done);
            if (n == 2) chk("addr", exp_addr, o_addr);
            if (n == 5) chk("data", res, dest ? o_wr_data : o_w_data);
            if (n == done_n) begin
                chk("cycles", cyc, o_cycles);
                chk("next pc", pc + {18'h0, cyc, 1'b0}, o_pc);
            end
        end
        $display("test %s ended", name);
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////////////////
    // scenarios
    // low access page, result back to the register, no skip
    task automatic t_plain_reg();
        run_op("plain_reg", 8'h23, 1'b1, 1'b0, 1'b0, 4'h3, 1'b0,
               12'h000, 8'h80, 12'h023);
    endtask : t_plain_reg

    // banked access ignores the extended set, wrap 00h to ffh into the accumulator
    task automatic t_banked_acc();
        run_op("banked_acc", 8'h5f, 1'b0, 1'b1, 1'b0, 4'h9, 1'b1,
               12'h400, 8'h00, 12'h95f);
    endtask : t_banked_acc

    // first address past the literal range stays direct, zero result skips once
    task automatic t_skip_single();
        run_op("skip_single", 8'h60, 1'b1, 1'b0, 1'b0, 4'h2, 1'b1,
               12'h300, 8'h01, 12'hf60);
    endtask : t_skip_single

    // top of the literal range is indexed, with wrap; skipped two-word follower
    task automatic t_skip_double();
        run_op("skip_double", 8'h5f, 1'b0, 1'b0, 1'b1, 4'h5, 1'b1,
               12'hfa8, 8'h01, 12'h007);
    endtask : t_skip_double

    // a two-word follower costs nothing when there is no skip
    task automatic t_no_skip_two();
        run_op("no_skip_two", 8'hff, 1'b1, 1'b0, 1'b1, 4'h7, 1'b0,
               12'h100, 8'h02, 12'hfff);
    endtask : t_no_skip_two

    ////////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        // the synchroniser needs its edges before the first issue
        repeat (3) @(posedge i_sys_clk);
        t_plain_reg();
        t_banked_acc();
        t_skip_single();
        t_skip_double();
        t_no_skip_two();
        repeat (2) @(posedge i_sys_clk);
        summarize();
    end

    // whole run is well under a thousand clocks
    initial begin
        #20000;
        failures++;
        summarize();
    end
endmodule : dsz_exec_bench
`default_nettype wire

// file: verilog/dsz_addr_resolve.sv
// data memory address resolution for a byte-oriented operand
`default_nettype none
module dsz_addr_resolve (
    // operand
    input  wire logic [7:0]                      i_f,
    input  wire logic                            i_bank,
    input  wire logic                            i_ext_en,
    input  wire logic [dsz_pkg::DSZ_BSR_W-1:0]   i_bsr,
    input  wire logic [dsz_pkg::DSZ_ADDR_W-1:0]  i_index_base,
    // result
    output logic      [dsz_pkg::DSZ_ADDR_W-1:0]  o_addr,
    output dsz_pkg::dsz_mode_e                   o_mode
);
    import dsz_pkg::*;

    // indexed wins over plain access only with the extended set on
    always_comb begin
        if (i_bank) begin
            o_mode = DSZ_MODE_BANKED;
            o_addr = {i_bsr, i_f};
        end else if (i_ext_en && (i_f <= DSZ_LITERAL_MAX)) begin
            o_mode = DSZ_MODE_INDEXED;
            o_addr = i_index_base + {4'h0, i_f};
        end else begin
            o_mode = DSZ_MODE_ACCESS;
            o_addr = (i_f < DSZ_ACCESS_SPLIT) ? {DSZ_LOW_PAGE, i_f}
                                              : {DSZ_SFR_PAGE, i_f};
        end
    end
endmodule : dsz_addr_resolve
`default_nettype wire

// file: verilog/dsz_exec.sv
// executor of the decrement-and-skip-on-zero instruction, one clock per phase
`default_nettype none
// Behaviour
// - the decremented byte goes to the accumulator if dest is 0, else back to the register.
// - a zero result drops the fetched next instruction and runs one idle cycle, two in all.
// - a skipped two-word instruction costs two no-operation cycles, three cycles total.
// - with the bank bit 0 and indexed mode not selected the address lies in the fixed access bank.
// - with the bank bit 1 the bank select register extends the address into banked ram.
// - bank bit 0, extended set on and address at most 5Fh select indexed literal offset mode.
// - a non-zero result continues at the following instruction, program counter plus 2.
module dsz_exec (
    // clock and reset
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_resetn,
    // instruction issue
    input  wire logic                            i_start,
    input  wire dsz_pkg::dsz_req_s               i_req,
    input  wire logic [dsz_pkg::DSZ_PC_W-1:0]    i_pc,
    input  wire logic [dsz_pkg::DSZ_BSR_W-1:0]   i_bsr,
    input  wire logic                            i_ext_en,
    input  wire logic [dsz_pkg::DSZ_ADDR_W-1:0]  i_index_base,
    // data memory
    input  wire logic [dsz_pkg::DSZ_DATA_W-1:0]  i_rd_data,
    output logic                                 o_rd_en,
    output logic      [dsz_pkg::DSZ_ADDR_W-1:0]  o_addr,
    output logic                                 o_wr_en,
    output logic      [dsz_pkg::DSZ_DATA_W-1:0]  o_wr_data,
    // accumulator
    output logic                                 o_w_wr_en,
    output logic      [dsz_pkg::DSZ_DATA_W-1:0]  o_w_data,
    // sequencing
    output logic                                 o_busy,
    output logic      [1:0]                      o_phase,
    output logic                                 o_flush,
    output logic                                 o_done,
    output logic      [1:0]                      o_cycles,
    output logic      [dsz_pkg::DSZ_PC_W-1:0]    o_pc
);
    import dsz_pkg::*;

    typedef struct packed {
        dsz_state_e                 state;
        dsz_phase_e                 phase;
        dsz_req_s                   req;
        logic                       ext_en;
        logic [DSZ_BSR_W-1:0]       bank_select_register;
        logic [DSZ_ADDR_W-1:0]      index_base;
        logic [DSZ_PC_W-1:0]        pc_base;
        dsz_mode_e                  mode;
        logic [DSZ_DATA_W-1:0]      result;
        logic                       rd_en;
        logic [DSZ_ADDR_W-1:0]      addr;
        logic                       wr_en;
        logic [DSZ_DATA_W-1:0]      wr_data;
        logic                       w_wr_en;
        logic [DSZ_DATA_W-1:0]      w_data;
        logic                       flush;
        logic                       done;
        logic [1:0]                 cycles;
        logic [DSZ_PC_W-1:0]        pc;
        logic                       busy;
    } dsz_core_s;

    dsz_core_s              core_reg;
    dsz_core_s              core_next;
    logic [1:0]             rst_sync_reg;
    logic                   rst_n;
    logic [DSZ_ADDR_W-1:0]  res_addr;
    dsz_mode_e              res_mode;

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops, asserted at once
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // address source from the latched operand, so mid-instruction input changes are harmless
    dsz_addr_resolve i_dsz_addr_resolve (
        .i_f          (core_reg.req.f),
        .i_bank       (core_reg.req.bank),
        .i_ext_en     (core_reg.ext_en),
        .i_bsr        (core_reg.bank_select_register),
        .i_index_base (core_reg.index_base),
        .o_addr       (res_addr),
        .o_mode       (res_mode)
    );

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer; strobes are single-cycle and default low
    always_comb begin
        core_next         = core_reg;
        core_next.rd_en   = 1'b0;
        core_next.wr_en   = 1'b0;
        core_next.w_wr_en = 1'b0;
        core_next.flush   = 1'b0;
        core_next.done    = 1'b0;
        case (core_reg.state)
            DSZ_IDLE: begin
                if (i_start) begin
                    core_next.state      = DSZ_EXEC;
                    core_next.phase      = DSZ_Q1;
                    core_next.req        = i_req;
                    core_next.ext_en     = i_ext_en;
                    core_next.bank_select_register        = i_bsr;
                    core_next.index_base = i_index_base;
                    core_next.pc_base    = i_pc;
                end
            end
            DSZ_EXEC: begin
                case (core_reg.phase)
                    DSZ_Q1: begin
                        core_next.addr  = res_addr;
                        core_next.mode  = res_mode;
                        core_next.phase = DSZ_Q2;
                    end
                    DSZ_Q2: begin
                        core_next.rd_en = 1'b1;
                        core_next.phase = DSZ_Q3;
                    end
                    DSZ_Q3: begin
                        core_next.result = i_rd_data - DSZ_DEC_STEP;
                        core_next.phase  = DSZ_Q4;
                    end
                    DSZ_Q4: begin
                        if (core_reg.req.dest) begin
                            core_next.wr_en   = 1'b1;
                            core_next.wr_data = core_reg.result;
                        end else begin
                            core_next.w_wr_en = 1'b1;
                            core_next.w_data  = core_reg.result;
                        end
                        core_next.phase = DSZ_Q1;
                        if (core_reg.result == DSZ_ZERO) begin
                            core_next.flush = 1'b1;
                            core_next.state = DSZ_SKIP;
                        end else begin
                            core_next.done   = 1'b1;
                            core_next.cycles = DSZ_CYC_PLAIN;
                            core_next.pc     = core_reg.pc_base + DSZ_PC_STEP1;
                            core_next.state  = DSZ_IDLE;
                        end
                    end
                    default: begin
                        core_next.phase = DSZ_Q1;
                    end
                endcase
            end
            DSZ_SKIP, DSZ_SKIP2: begin
                // no memory or accumulator strobe in any skip phase
                case (core_reg.phase)
                    DSZ_Q1:  core_next.phase = DSZ_Q2;
                    DSZ_Q2:  core_next.phase = DSZ_Q3;
                    DSZ_Q3:  core_next.phase = DSZ_Q4;
                    default: core_next.phase = DSZ_Q1;
                endcase
                if (core_reg.phase == DSZ_Q4) begin
                    if (core_reg.state == DSZ_SKIP && core_reg.req.two_word) begin
                        core_next.state = DSZ_SKIP2;
                    end else if (core_reg.state == DSZ_SKIP) begin
                        core_next.done   = 1'b1;
                        core_next.cycles = DSZ_CYC_SKIP;
                        core_next.pc     = core_reg.pc_base + DSZ_PC_STEP2;
                        core_next.state  = DSZ_IDLE;
                    end else begin
                        core_next.done   = 1'b1;
                        core_next.cycles = DSZ_CYC_SKIP2;
                        core_next.pc     = core_reg.pc_base + DSZ_PC_STEP3;
                        core_next.state  = DSZ_IDLE;
                    end
                end
            end
            default: begin
                core_next.state = DSZ_IDLE;
            end
        endcase
        // busy is kept in a flop so the output carries no decode glitch
        core_next.busy = (core_next.state != DSZ_IDLE);
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reg        <= '0;
            core_reg.cycles <= DSZ_CYC_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flops
    assign o_rd_en   = core_reg.rd_en;
    assign o_addr    = core_reg.addr;
    assign o_wr_en   = core_reg.wr_en;
    assign o_wr_data = core_reg.wr_data;
    assign o_w_wr_en = core_reg.w_wr_en;
    assign o_w_data  = core_reg.w_data;
    assign o_busy    = core_reg.busy;
    assign o_phase   = core_reg.phase;
    assign o_flush   = core_reg.flush;
    assign o_done    = core_reg.done;
    assign o_cycles  = core_reg.cycles;
    assign o_pc      = core_reg.pc;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_reg_write_value: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_wr_en |-> !o_w_wr_en && core_reg.req.dest &&
                    (o_wr_data == 8'($past(i_rd_data, 2) - DSZ_DEC_STEP)))
        else $error("register write value wrong");
    a_acc_write_value: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_w_wr_en |-> !core_reg.req.dest &&
                      (o_w_data == 8'($past(i_rd_data, 2) - DSZ_DEC_STEP)))
        else $error("accumulator write value wrong");
    a_flush_on_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_wr_en && o_wr_data == DSZ_ZERO) || (o_w_wr_en && o_w_data == DSZ_ZERO)
        |-> o_flush)
        else $error("zero result did not flush");
    a_skip_one_len: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_flush && !core_reg.req.two_word) |-> !o_done [*4] ##1
        (o_done && o_cycles == DSZ_CYC_SKIP && o_pc == core_reg.pc_base + DSZ_PC_STEP2))
        else $error("single skip length wrong");
    a_skip_two_len: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_flush && core_reg.req.two_word) |-> ##8
        (o_done && o_cycles == DSZ_CYC_SKIP2 && o_pc == core_reg.pc_base + DSZ_PC_STEP3))
        else $error("double skip length wrong");
    a_access_addr: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_rd_en && !core_reg.req.bank && core_reg.mode != DSZ_MODE_INDEXED) |->
        o_addr[7:0] == core_reg.req.f &&
        o_addr[11:8] == ((core_reg.req.f < DSZ_ACCESS_SPLIT) ? DSZ_LOW_PAGE : DSZ_SFR_PAGE))
        else $error("access bank address wrong");
    a_banked_addr: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_rd_en && core_reg.req.bank) |-> o_addr == {core_reg.bank_select_register, core_reg.req.f})
        else $error("banked address wrong");
    a_indexed_sel: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_rd_en |-> ((core_reg.mode == DSZ_MODE_INDEXED) == (!core_reg.req.bank &&
                     core_reg.ext_en && core_reg.req.f <= DSZ_LITERAL_MAX)))
        else $error("indexed mode selection wrong");
    a_plain_pc: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_done && !$past(o_busy, 5)) |-> o_cycles == DSZ_CYC_PLAIN &&
        o_pc == core_reg.pc_base + DSZ_PC_STEP1)
        else $error("non-skip exit wrong");
    a_phase_order: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        $rose(o_busy) |-> ##2 o_rd_en && o_phase == DSZ_Q3 ##2
        (o_wr_en || o_w_wr_en) && o_phase == DSZ_Q1)
        else $error("phase order wrong");
    a_skip_quiet: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (core_reg.state == DSZ_SKIP2 || (core_reg.state == DSZ_SKIP && o_phase != DSZ_Q1))
        |-> !o_rd_en && !o_wr_en && !o_w_wr_en && !o_flush)
        else $error("activity in skip cycle");
endmodule : dsz_exec
`default_nettype wire

// file: verilog/dsz_pkg.sv
// package: shared widths, encodings and carriers of the decrement-and-skip executor
`default_nettype none
package dsz_pkg;
    localparam int          DSZ_DATA_W      = 8;
    localparam int          DSZ_ADDR_W      = 12;
    localparam int          DSZ_BSR_W       = 4;
    localparam int          DSZ_PC_W        = 21;
    // access bank splits into low ram and the special register page
    localparam logic [7:0]  DSZ_ACCESS_SPLIT = 8'h60;
    localparam logic [7:0]  DSZ_LITERAL_MAX  = 8'h5f;
    localparam logic [3:0]  DSZ_LOW_PAGE     = 4'h0;
    localparam logic [3:0]  DSZ_SFR_PAGE     = 4'hf;
    localparam logic [7:0]  DSZ_DEC_STEP     = 8'h01;
    localparam logic [7:0]  DSZ_ZERO         = 8'h00;
    // program counter advance per cycle, in byte addresses
    localparam logic [20:0] DSZ_PC_STEP1     = 21'h000002;
    localparam logic [20:0] DSZ_PC_STEP2     = 21'h000004;
    localparam logic [20:0] DSZ_PC_STEP3     = 21'h000006;
    localparam logic [1:0]  DSZ_CYC_PLAIN    = 2'h1;
    localparam logic [1:0]  DSZ_CYC_SKIP     = 2'h2;
    localparam logic [1:0]  DSZ_CYC_SKIP2    = 2'h3;
    localparam logic [1:0]  DSZ_CYC_RESET    = 2'h0;

    // four phases of one instruction cycle, gray ordered
    typedef enum logic [1:0] {
        DSZ_Q1 = 2'h0,
        DSZ_Q2 = 2'h1,
        DSZ_Q3 = 2'h3,
        DSZ_Q4 = 2'h2
    } dsz_phase_e;

    typedef enum logic [1:0] {
        DSZ_IDLE  = 2'h0,
        DSZ_EXEC  = 2'h1,
        DSZ_SKIP  = 2'h3,
        DSZ_SKIP2 = 2'h2
    } dsz_state_e;

    typedef enum logic [1:0] {
        DSZ_MODE_ACCESS  = 2'h0,
        DSZ_MODE_BANKED  = 2'h1,
        DSZ_MODE_INDEXED = 2'h2
    } dsz_mode_e;

    // operand fields of one issued instruction
    typedef struct packed {
        logic [7:0] f;
        logic       dest;
        logic       bank;
        logic       two_word;
    } dsz_req_s;
endpackage : dsz_pkg
`default_nettype wire
